// *** core/adc_status_consts.vh ***
// constants for the adc status flag block
// assumes a 12-bit byte offset within the adc register page
`ifndef ADC_STATUS_CONSTS_VH
`define ADC_STATUS_CONSTS_VH

// ****************************************************
// register offsets
// ****************************************************
`define OFS_STATUS 12'h500
`define OFS_MASK 12'h504
`define OFS_MODE 12'h508
`define OFS_CUR_RES 12'h50C
`define OFS_VOLT_RES 12'h510
`define OFS_TEMP_RES 12'h514

// ****************************************************
// status word bit positions
// ****************************************************
`define BIT_CAL_DONE 15
`define BIT_TEMP_ERR 14
`define BIT_VOLT_ERR 13
`define BIT_CUR_ERR 12
`define BIT_CMP 4
`define BIT_OVR 3
`define BIT_TEMP_RDY 2
`define BIT_VOLT_RDY 1
`define BIT_CUR_RDY 0

// ****************************************************
// reset values and clamp codes
// ****************************************************
`define RST_STATUS 16'h0000
`define RST_MASK 8'h00
`define RST_RESULT 16'h0000
`define CLAMP_NEG 16'h8000
`define CLAMP_POS 16'h7FFF

// ****************************************************
// timing
// ****************************************************
`define CLK_PERIOD_NS 10
`define OVR_PERIOD_US 125
`define OVR_PERIOD_CYC ((`OVR_PERIOD_US * 1000) / `CLK_PERIOD_NS)

`endif

// *** core/adc_status_flag_logic.v ***
// adc status word, interrupt mask and result-ready flag logic
// assumes converters deliver one-cycle result strobes on i_clk and that
// the core bus gives one-cycle read and write strobes with an offset
//
// Summary of operation
// - calibration flag set on finish, mode write clears
// - temperature range error sets bit 14
// - out-of-range results clamp to full scale
// - stored in-range temperature result clears bit 14
// - voltage error bit 13 set/clear likewise
// - current error bit 12 set/clear likewise
// - bits 11 to 5 reserved, read zero
// - comparator flag when current magnitude exceeds threshold
// - threshold counter delays comparator flag
// - over-range flag on gross input overload
// - over-range flag evaluated every 125 us
// - over-range sticky until disable or gain change
// - temperature ready set, cleared by temp/current read
// - voltage ready set, cleared by volt/current read
// - current ready set, cleared by current read
// - calibration end sets enabled channels' ready
// - bits 15 to 8 never interrupt
// - lower byte ORed into one interrupt
// - per-bit interrupt mask, resets to zero
// - results held until ready cleared, except powerdown
// - current off: volt/temp read clears all ready
`timescale 1ns/1ps
`default_nettype none
`include "adc_status_consts.vh"

module adc_status_flag_logic #(
    parameter OVR_PERIOD = `OVR_PERIOD_CYC,
    parameter CNT_W = 8
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_mmr_rd,
    input wire i_mmr_wr,
    input wire [11:0] i_mmr_addr,
    input wire [15:0] i_mmr_wdata,
    output reg [15:0] o_mmr_rdata,
    output reg o_adc_irq,
    input wire i_cal_done,
    input wire i_cur_en,
    input wire i_volt_en,
    input wire i_temp_en,
    input wire i_cur_valid,
    input wire [15:0] i_cur_data,
    input wire i_cur_over,
    input wire i_cur_under,
    input wire i_volt_valid,
    input wire [15:0] i_volt_data,
    input wire i_volt_over,
    input wire i_volt_under,
    input wire i_temp_valid,
    input wire [15:0] i_temp_data,
    input wire i_temp_over,
    input wire i_temp_under,
    input wire i_cmp_en,
    input wire i_thr_cnt_en,
    input wire [15:0] i_current_threshold_level,
    input wire [CNT_W-1:0] i_threshold_count_limit,
    input wire i_ovr_det_en,
    input wire i_gain_change,
    input wire i_ovr_pin,
    input wire i_core_powered_down,
    output reg [15:0] o_current_result_word,
    output reg [15:0] o_voltage_result_word,
    output reg [15:0] o_temperature_result_word
);

    // ****************************************************
    // helpers
    // ****************************************************
    // clamp a raw result to the full-scale codes
    function [15:0] clamp;
        input [15:0] raw;
        input over;
        input under;
        begin
            if (under)
                clamp = `CLAMP_NEG;
            else if (over)
                clamp = `CLAMP_POS;
            else
                clamp = raw;
        end
    endfunction
    // magnitude of a signed word; 17 bits so -32768 fits
    function [16:0] mag;
        input [15:0] v;
        begin
            if (v[15]) begin
                mag = {1'b0, ~v} + 17'h00001;
            end else begin
                mag = {1'b0, v};
            end
        end
    endfunction

    // ****************************************************
    // bus decode
    // ****************************************************
    wire rd_cur = i_mmr_rd && (i_mmr_addr == `OFS_CUR_RES);
    wire rd_volt = i_mmr_rd && (i_mmr_addr == `OFS_VOLT_RES);
    wire rd_temp = i_mmr_rd && (i_mmr_addr == `OFS_TEMP_RES);
    wire wr_mask = i_mmr_wr && (i_mmr_addr == `OFS_MASK);
    wire wr_mode = i_mmr_wr && (i_mmr_addr == `OFS_MODE);

    // ****************************************************
    // result storage
    // ****************************************************
    reg cal_flag, temp_err, volt_err, cur_err, cmp_flag, ovr_flag, temp_rdy;
    reg volt_rdy, cur_rdy;
    reg [7:0] mask;

    // new result is accepted only once the old one was consumed, or while powered down
    wire cur_store = i_cur_valid && (!cur_rdy || i_core_powered_down);
    wire volt_store = i_volt_valid && (!volt_rdy || i_core_powered_down);
    wire temp_store = i_temp_valid && (!temp_rdy || i_core_powered_down);
    wire cur_bad = i_cur_over || i_cur_under;
    wire volt_bad = i_volt_over || i_volt_under;
    wire temp_bad = i_temp_over || i_temp_under;

    // result registers hold clamped data
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_current_result_word <= `RST_RESULT;
            o_voltage_result_word <= `RST_RESULT;
            o_temperature_result_word <= `RST_RESULT;
        end else begin
            if (cur_store) begin
                o_current_result_word <= clamp(i_cur_data, i_cur_over,
                    i_cur_under);
            end
            if (volt_store) begin
                o_voltage_result_word <= clamp(i_volt_data, i_volt_over,
                    i_volt_under);
            end
            if (temp_store) begin
                o_temperature_result_word <= clamp(i_temp_data,
                    i_temp_over, i_temp_under);
            end
        end
    end

    // ****************************************************
    // calibration and range error flags
    // ****************************************************
    // set terms are last so an event on a clear cycle is kept
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cal_flag <= 1'b0;
            temp_err <= 1'b0;
            volt_err <= 1'b0;
            cur_err <= 1'b0;
        end else begin
            if (wr_mode) begin
                cal_flag <= 1'b0;
            end
            if (i_cal_done) begin
                cal_flag <= 1'b1;
            end
            if (temp_store && !temp_bad) begin
                temp_err <= 1'b0;
            end
            if (i_temp_valid && temp_bad) begin
                temp_err <= 1'b1;
            end
            if (volt_store && !volt_bad) begin
                volt_err <= 1'b0;
            end
            if (i_volt_valid && volt_bad) begin
                volt_err <= 1'b1;
            end
            if (cur_store && !cur_bad) begin
                cur_err <= 1'b0;
            end
            if (i_cur_valid && cur_bad) begin
                cur_err <= 1'b1;
            end
        end
    end

    // ****************************************************
    // current comparator with threshold counter
    // ****************************************************
    reg [CNT_W-1:0] exceed_cnt;
    wire [16:0] cur_mag = mag(clamp(i_cur_data, i_cur_over, i_cur_under));
    wire exceed = i_cur_valid && i_cmp_en &&
        (cur_mag > {1'b0, i_current_threshold_level});
    wire [CNT_W-1:0] next_exceed_cnt = exceed_cnt + 1'b1;
    wire rd_status = i_mmr_rd && (i_mmr_addr == `OFS_STATUS);

    // flag clears on a status read; a hit in that cycle still sets it
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            exceed_cnt <= {CNT_W{1'b0}};
            cmp_flag <= 1'b0;
        end else begin
            if (rd_status) begin
                cmp_flag <= 1'b0;
            end
            if (!i_cmp_en || !i_thr_cnt_en) begin
                exceed_cnt <= {CNT_W{1'b0}};
                if (exceed) begin
                    cmp_flag <= 1'b1;
                end
            end else if (exceed) begin
                if (next_exceed_cnt == i_threshold_count_limit) begin
                    cmp_flag <= 1'b1;
                    exceed_cnt <= {CNT_W{1'b0}};
                end else begin
                    exceed_cnt <= next_exceed_cnt;
                end
            end
        end
    end

    // ****************************************************
    // gross over-range detection
    // ****************************************************
    // detector pin is asynchronous: three stages, act when 2nd and 3rd agree
    reg [2:0] ovr_sync;
    reg ovr_level;
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ovr_sync <= 3'h0;
            ovr_level <= 1'b0;
        end else begin
            ovr_sync <= {ovr_sync[1:0], i_ovr_pin};
            if (ovr_sync[1] == ovr_sync[2]) begin
                ovr_level <= ovr_sync[2];
            end
        end
    end
    // free-running interval tick
    reg [31:0] ovr_timer;
    wire ovr_tick = (ovr_timer == OVR_PERIOD - 1);
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ovr_timer <= 32'h00000000;
        end else if (ovr_tick) begin
            ovr_timer <= 32'h00000000;
        end else begin
            ovr_timer <= ovr_timer + 32'h00000001;
        end
    end

    // sticky; a tick in a gain-change cycle still sets it
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ovr_flag <= 1'b0;
        end else begin
            if (!i_ovr_det_en || i_gain_change) begin
                ovr_flag <= 1'b0;
            end
            if (ovr_tick && i_ovr_det_en && ovr_level) begin
                ovr_flag <= 1'b1;
            end
        end
    end

    // ****************************************************
    // result-ready flags
    // ****************************************************
    wire rd_vt = rd_volt || rd_temp;
    wire clr_temp = rd_temp || rd_cur || (!i_cur_en && rd_vt);
    wire clr_volt = rd_volt || rd_cur || (!i_cur_en && rd_vt);
    wire clr_cur = rd_cur || (!i_cur_en && rd_vt);

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            temp_rdy <= 1'b0;
            volt_rdy <= 1'b0;
            cur_rdy <= 1'b0;
        end else begin
            if (clr_temp) begin
                temp_rdy <= 1'b0;
            end
            if (clr_volt) begin
                volt_rdy <= 1'b0;
            end
            if (clr_cur) begin
                cur_rdy <= 1'b0;
            end
            if (i_temp_en && (temp_store || i_cal_done)) begin
                temp_rdy <= 1'b1;
            end
            if (i_volt_en && (volt_store || i_cal_done)) begin
                volt_rdy <= 1'b1;
            end
            if (i_cur_en && (cur_store || i_cal_done)) begin
                cur_rdy <= 1'b1;
            end
        end
    end

    // ****************************************************
    // status word, mask, interrupt and read data
    // ****************************************************
    // reserved bits 11..5 read as zero
    wire [15:0] status = {cal_flag, temp_err, volt_err, cur_err,
        7'h00, cmp_flag, ovr_flag, temp_rdy, volt_rdy, cur_rdy};

    // mask register only covers the interrupting low byte
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mask <= `RST_MASK;
        end else if (wr_mask) begin
            mask <= i_mmr_wdata[7:0];
        end
    end

    // only the low byte can interrupt; a level, not a pulse
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_adc_irq <= 1'b0;
        end else begin
            o_adc_irq <= |(status[7:0] & mask);
        end
    end

    // registered read data; unmapped offsets read zero
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mmr_rdata <= 16'h0000;
        end else if (i_mmr_rd) begin
            case (i_mmr_addr)
                `OFS_STATUS: o_mmr_rdata <= status;
                `OFS_MASK: o_mmr_rdata <= {8'h00, mask};
                `OFS_CUR_RES: o_mmr_rdata <= o_current_result_word;
                `OFS_VOLT_RES: o_mmr_rdata <= o_voltage_result_word;
                `OFS_TEMP_RES: o_mmr_rdata <= o_temperature_result_word;
                default: o_mmr_rdata <= 16'h0000;
            endcase
        end
    end

endmodule // adc_status_flag_logic
`default_nettype wire

// *** dv/adc_status_flag_logic_properties.sv ***
// port-level properties of the adc status flag block
// assumes one-cycle read strobes with an idle cycle after each read
`timescale 1ns/1ps
`default_nettype none
`include "adc_status_consts.vh"

module adc_status_flag_logic_properties (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_mmr_rd,
    input wire logic [11:0] i_mmr_addr,
    input wire logic [15:0] o_mmr_rdata,
    input wire logic i_core_powered_down,
    input wire logic i_cur_valid,
    input wire logic [15:0] i_cur_data,
    input wire logic i_cur_over,
    input wire logic i_cur_under,
    input wire logic i_volt_valid,
    input wire logic i_volt_over,
    input wire logic i_volt_under,
    input wire logic [15:0] o_current_result_word,
    input wire logic [15:0] o_voltage_result_word
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // read data is judged once the idle cycle has let it settle
    rsvd_read_zero_a: assert property (i_mmr_rd &&
        i_mmr_addr == `OFS_STATUS ##1 !i_mmr_rd |=> o_mmr_rdata[11:5] == 7'h00)
        else $error("reserved status bits not zero");
    unmapped_read_a: assert property (i_mmr_rd && i_mmr_addr > 12'h514
        ##1 !i_mmr_rd |=> o_mmr_rdata == 16'h0000)
        else $error("unmapped read not zero");
    mask_upper_zero_a: assert property (i_mmr_rd &&
        i_mmr_addr == `OFS_MASK ##1 !i_mmr_rd |=> o_mmr_rdata[15:8] == 8'h00)
        else $error("mask upper byte not zero");
    // under wins when both qualifiers come with one strobe
    cur_clamp_a: assert property (i_cur_valid && i_core_powered_down &&
        (i_cur_over || i_cur_under) |=> o_current_result_word ==
        ($past(i_cur_under) ? `CLAMP_NEG : `CLAMP_POS))
        else $error("current result not clamped");
    volt_clamp_a: assert property (i_volt_valid && i_core_powered_down &&
        (i_volt_over || i_volt_under) |=> o_voltage_result_word ==
        ($past(i_volt_under) ? `CLAMP_NEG : `CLAMP_POS))
        else $error("voltage result not clamped");
    cur_store_pd_a: assert property (i_cur_valid && i_core_powered_down &&
        !i_cur_over && !i_cur_under |=> o_current_result_word == $past(i_cur_data))
        else $error("current result not stored");
    cur_hold_a: assert property (!i_cur_valid |=>
        $stable(o_current_result_word))
        else $error("current result moved without strobe");
    volt_hold_a: assert property (!i_volt_valid |=>
        $stable(o_voltage_result_word))
        else $error("voltage result moved without strobe");
endmodule // adc_status_flag_logic_properties

bind adc_status_flag_logic adc_status_flag_logic_properties chk_u (
    .i_clk, .i_rst, .i_mmr_rd, .i_mmr_addr, .o_mmr_rdata,
    .i_core_powered_down, .i_cur_valid, .i_cur_data, .i_cur_over,
    .i_cur_under, .i_volt_valid, .i_volt_over, .i_volt_under,
    .o_current_result_word, .o_voltage_result_word);
`default_nettype wire

// *** dv/core_bus_model.sv ***
// processor core side of the register bus: one-cycle read/write strobes
// the task waits for the clock itself; drives only at falling edges
`timescale 1ns/1ps
`default_nettype none

module core_bus_model (
    input wire logic i_clk,
    output logic o_rd,
    output logic o_wr,
    output logic [11:0] o_addr,
    output logic [15:0] o_wdata,
    input wire logic [15:0] i_rdata
);
    initial begin
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_addr = 12'hFFF;
        o_wdata = 16'hFFFF;
    end

    // released lines show the inverse so stale values never pass
    task xfer(input logic wr, input logic [11:0] a, input logic [15:0] d,
        output logic [15:0] q);
        @(negedge i_clk);
        {o_rd, o_wr, o_addr, o_wdata} = {!wr, wr, a, d};
        @(negedge i_clk);
        {o_rd, o_wr, o_addr, o_wdata} = {2'b00, ~a, ~d};
        @(negedge i_clk);
        q = i_rdata;
    endtask
endmodule // core_bus_model
`default_nettype wire

// *** dv/adc_status_flag_logic_tb.sv ***
// self-checking bench for the adc status flag block
// assumes core/ on the include path; over-range tick shortened to 20
`timescale 1ns/1ps
`default_nettype none
`include "adc_status_consts.vh"

module adc_status_flag_logic_tb;
    logic i_clk = 0, i_rst = 1, i_cal_done = 0, i_gain_change = 0;
    logic i_cur_en = 1, i_volt_en = 1, i_temp_en = 1, i_core_powered_down = 0;
    logic i_cur_valid = 0, i_cur_over = 0, i_cur_under = 0;
    logic i_volt_valid = 0, i_volt_over = 0, i_volt_under = 0;
    logic i_temp_valid = 0, i_temp_over = 0, i_temp_under = 0;
    logic [15:0] i_cur_data = 0, i_volt_data = 0, i_temp_data = 0;
    logic [15:0] i_current_threshold_level = 0, q, d, ebit, rbit;
    logic [7:0] i_threshold_count_limit = 0;
    logic i_cmp_en = 0, i_thr_cnt_en = 0, i_ovr_det_en = 0, i_ovr_pin = 0;
    wire i_mmr_rd, i_mmr_wr, o_adc_irq;
    wire [11:0] i_mmr_addr;
    wire [15:0] i_mmr_wdata, o_mmr_rdata, o_current_result_word;
    wire [15:0] o_voltage_result_word, o_temperature_result_word;
    int err_count = 0, total_checks = 0, ch, k;
    integer seed = 32'h38c94a22;

    adc_status_flag_logic #(.OVR_PERIOD(20), .CNT_W(8)) dut_u (.i_clk,
        .i_rst, .i_mmr_rd, .i_mmr_wr, .i_mmr_addr, .i_mmr_wdata, .o_mmr_rdata,
        .o_adc_irq, .i_cal_done, .i_cur_en, .i_volt_en, .i_temp_en,
        .i_cur_valid, .i_cur_data, .i_cur_over, .i_cur_under, .i_volt_valid,
        .i_volt_data, .i_volt_over, .i_volt_under, .i_temp_valid, .i_temp_data,
        .i_temp_over, .i_temp_under, .i_cmp_en, .i_thr_cnt_en,
        .i_current_threshold_level, .i_threshold_count_limit, .i_ovr_det_en,
        .i_gain_change, .i_ovr_pin, .i_core_powered_down,
        .o_current_result_word, .o_voltage_result_word,
        .o_temperature_result_word);
    core_bus_model bus_u (.i_clk, .o_rd(i_mmr_rd), .o_wr(i_mmr_wr),
        .o_addr(i_mmr_addr), .o_wdata(i_mmr_wdata), .i_rdata(o_mmr_rdata));

    always #5 i_clk = ~i_clk;

    // ****************************************************
    // helpers
    // ****************************************************
    task end_sim();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task rd(input logic [11:0] a, output logic [15:0] v);
        bus_u.xfer(1'b0, a, 16'h0000, v);
    endtask
    task wr(input logic [11:0] a, input logic [15:0] v);
        logic [15:0] dummy;
        bus_u.xfer(1'b1, a, v, dummy);
    endtask
    task cs(input logic [15:0] exp);
        rd(`OFS_STATUS, q);
        chk(q, exp);
    endtask
    task strobe(input int c, input logic [15:0] v, input logic ov, un);
        @(negedge i_clk);
        if (c == 0) {i_cur_valid, i_cur_data, i_cur_over, i_cur_under} =
            {1'b1, v, ov, un};
        if (c == 1) {i_volt_valid, i_volt_data, i_volt_over, i_volt_under} =
            {1'b1, v, ov, un};
        if (c == 2) {i_temp_valid, i_temp_data, i_temp_over, i_temp_under} =
            {1'b1, v, ov, un};
        @(negedge i_clk);
        {i_cur_valid, i_volt_valid, i_temp_valid} = 3'h0;
        @(negedge i_clk);
    endtask
    task cal();
        @(negedge i_clk) i_cal_done = 1;
        @(negedge i_clk) i_cal_done = 0;
        @(negedge i_clk);
    endtask
    // expected stored word: under wins over over
    function logic [15:0] f_clamp(input logic [15:0] v, input logic ov, un);
        return un ? 16'h8000 : (ov ? 16'h7FFF : v);
    endfunction
    function logic [11:0] f_ofs(input int c);
        return `OFS_CUR_RES + 12'(c * 4);
    endfunction

    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        repeat (20) @(negedge i_clk);
        i_rst = 0;
        cs(16'h0000);
        rd(`OFS_MASK, q);
        chk(q, 16'h0000);
        rd(12'h5FC, q);
        chk(q, 16'h0000);
        d = $random(seed);
        strobe(0, d, 1'b0, 1'b0);
        cs(16'h0001);
        chk({15'h0, o_adc_irq}, 16'h0000);
        wr(`OFS_MASK, 16'h00FF);
        chk({15'h0, o_adc_irq}, 16'h0001);
        strobe(0, ~d, 1'b0, 1'b0);
        rd(`OFS_CUR_RES, q);
        chk(q, d);
        cs(16'h0000);
        chk({15'h0, o_adc_irq}, 16'h0000);
        // every channel, both error codes, then an in-range repair
        i_core_powered_down = 1;
        for (ch = 0; ch < 3; ch++) for (k = 0; k < 2; k++) begin
            d = $random(seed);
            ebit = 16'h1 << (12 + ch);
            rbit = 16'h1 << ch;
            strobe(ch, d, !k, k);
            cs(ebit | rbit);
            rd(f_ofs(ch), q);
            chk(q, f_clamp(d, !k, k));
            cs(ebit);
            chk({15'h0, o_adc_irq}, 16'h0000);
            strobe(ch, d, 1'b0, 1'b0);
            cs(rbit);
            rd(`OFS_CUR_RES, q);
            cs(16'h0000);
        end
        cal();
        cs(16'h8007);
        wr(`OFS_MODE, 16'h0000);
        cs(16'h0007);
        rd(`OFS_CUR_RES, q);
        i_cur_en = 0;
        cal();
        cs(16'h8006);
        rd(`OFS_VOLT_RES, q);
        cs(16'h8000);
        wr(`OFS_MODE, 16'h0000);
        i_cur_en = 1;
        // a disabled channel must not take the calibration ready
        i_volt_en = 0;
        cal();
        cs(16'h8005);
        i_volt_en = 1;
        rd(`OFS_CUR_RES, q);
        wr(`OFS_MODE, 16'h0000);
        cs(16'h0000);
        // counted comparator on a negative result, then direct mode
        {i_cmp_en, i_thr_cnt_en} = 2'b11;
        i_current_threshold_level = 16'h0100;
        i_threshold_count_limit = 8'h03;
        for (k = 0; k < 5; k++) begin
            if (k == 3) i_thr_cnt_en = 0;
            strobe(0, (k == 3) ? 16'h0100 : 16'hFEFF, 1'b0, 1'b0);
            rd(`OFS_STATUS, q);
            chk(q & 16'h0010, (k == 2 || k == 4) ? 16'h0010 : 16'h0);
        end
        i_cmp_en = 0;
        rd(`OFS_CUR_RES, q);
        {i_ovr_det_en, i_ovr_pin} = 2'b11;
        repeat (60) @(negedge i_clk);
        cs(16'h0008);
        chk({15'h0, o_adc_irq}, 16'h0001);
        i_ovr_pin = 0;
        repeat (60) @(negedge i_clk);
        cs(16'h0008);
        @(negedge i_clk) i_gain_change = 1;
        @(negedge i_clk) i_gain_change = 0;
        repeat (30) @(negedge i_clk);
        cs(16'h0000);
        i_ovr_pin = 1;
        repeat (60) @(negedge i_clk);
        cs(16'h0008);
        i_ovr_det_en = 0;
        repeat (30) @(negedge i_clk);
        cs(16'h0000);
        end_sim();
    end

    // hang guard, well past the few hundred cycles the run needs
    initial begin
        #200000;
        err_count++;
        end_sim();
    end
endmodule // adc_status_flag_logic_tb
`default_nettype wire
